/* logic/mtb_bridge.v */
// Overview of operation
// - read credit never wraps, gates reads
// - split requests at max payload boundaries
// - translate address for every split packet
// - page count power of two, 1..512
// - pick legacy or msi from config
// - interrupt-disable bit 10 blocks legacy
// - msi only when msi enable bit 0
// - never both interrupt methods active
`timescale 1ns/1ps
`default_nettype none
`include "mtb_consts.vh"

module mtb_bridge #(
    parameter PAGES      = 16,
    parameter PAGE_BITS  = 20,
    parameter BW         = 8,
    parameter CPL_BUF_DW = 1024
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   srst,
    // memory-mapped slave port
    input  wire [31:0]            mm_address,
    input  wire                   mm_read,
    input  wire                   mm_write,
    input  wire [31:0]            mm_writedata,
    input  wire [BW-1:0]          mm_burstcount,
    output reg                    mm_waitrequest,
    output reg  [31:0]            mm_readdata,
    output reg                    mm_readdatavalid,
    // translation table write port
    input  wire                   tbl_wr,
    input  wire [8:0]             tbl_idx,
    input  wire [63-PAGE_BITS:0]  tbl_base,
    // configuration inputs
    input  wire [2:0]             cfg_max_payload,
    input  wire [15:0]            cfg_command,
    input  wire [15:0]            cfg_msi_ctrl,
    // outgoing request packets
    input  wire                   tx_ready,
    output reg                    tx_hdr_valid,
    output reg                    tx_is_write,
    output reg  [63:0]            tx_addr,
    output reg  [10:0]            tx_len,
    output reg                    tx_data_valid,
    output reg  [31:0]            tx_data,
    // returning completion data
    input  wire                   cpl_valid,
    input  wire [31:0]            cpl_data,
    // interrupts
    input  wire                   app_irq,
    input  wire                   msi_ack,
    output reg                    legacy_irq,
    output reg                    msi_req
);

    localparam S_IDLE  = 3'h0;
    localparam S_CMD   = 3'h1;
    localparam S_LOOK  = 3'h2;
    localparam S_WAITX = 3'h3;
    localparam S_CRED  = 3'h4;
    localparam S_HDR   = 3'h5;
    localparam S_WDATA = 3'h6;
    localparam CW      = ($clog2(CPL_BUF_DW + 1) + 1 > 12) ? $clog2(CPL_BUF_DW + 1) + 1 : 12;
    localparam [CW-1:0] CRED_MAX = CPL_BUF_DW;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // boundary-limited chunk
    function [10:0] mtb_chunk;
        input [31:0] a;
        input [10:0] rem;
        input [2:0]  mps;
        reg   [2:0]  m;
        reg   [12:0] span;
        reg   [12:0] off;
        reg   [12:0] room;
        begin
            m         = (mps > `MTB_MPS_MAX_CODE) ? `MTB_MPS_MAX_CODE : mps;
            span      = `MTB_MPS_BASE_BYTES << m;
            off       = a[12:0] & (span - 13'h0001);
            room      = span - off;
            mtb_chunk = (rem < room[12:2]) ? rem : room[12:2];
        end
    endfunction

    function [CW-1:0] mtb_ext;
        input [10:0] v;
        begin
            mtb_ext = {{(CW-11){1'b0}}, v};
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg  [2:0]     state_reg;
    reg            dir_w_reg;
    reg            first_reg;
    reg  [31:0]    addr_reg;
    reg  [10:0]    rem_reg;
    reg  [10:0]    chunk_reg;
    reg  [10:0]    cnt_reg;
    reg  [31:0]    wbuf_reg;
    reg            xstart_reg;
    reg  [CW-1:0]  free_reg;
    reg  [CW-1:0]  free_next;
    reg            irq_prev_reg;
    wire           xdone;
    wire [63:0]    xaddr;

    wire [10:0] burst_ext = {{(11-BW){1'b0}}, mm_burstcount};
    wire [10:0] first_len = mtb_chunk(mm_address, burst_ext, cfg_max_payload);
    wire        take      = (state_reg == S_HDR) && tx_hdr_valid && tx_ready && !dir_w_reg;

    mtb_xlat #(
        .PAGES     (PAGES),
        .PAGE_BITS (PAGE_BITS)
    ) u_xlat (
        .clk         (clk),
        .srst        (srst),
        .wr_en       (tbl_wr),
        .wr_idx      (tbl_idx),
        .wr_base     (tbl_base),
        .look_start  (xstart_reg),
        .look_addr   (addr_reg),
        .look_done   (xdone),
        .look_result (xaddr)
    );

    // ------------------------------------------------------------
    // completion credit
    // ------------------------------------------------------------
    // saturating credit count
    always @* begin
        free_next = free_reg - (take ? mtb_ext(chunk_reg) : {CW{1'b0}});
        if (cpl_valid && free_next < CRED_MAX) begin
            free_next = free_next + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            free_reg         <= CRED_MAX;
            mm_readdata      <= 32'h00000000;
            mm_readdatavalid <= 1'b0;
        end else begin
            free_reg         <= free_next;
            mm_readdata      <= cpl_data;
            mm_readdatavalid <= cpl_valid;
        end
    end

    // ------------------------------------------------------------
    // request sequencer
    // ------------------------------------------------------------
    // the first write word is held in wbuf so the command beat and data beat share one accept
    always @(posedge clk) begin
        if (srst) begin
            state_reg      <= S_IDLE;
            mm_waitrequest <= 1'b1;
            dir_w_reg      <= 1'b0;
            first_reg      <= 1'b0;
            addr_reg       <= 32'h00000000;
            rem_reg        <= 11'h000;
            chunk_reg      <= 11'h000;
            cnt_reg        <= 11'h000;
            wbuf_reg       <= 32'h00000000;
            xstart_reg     <= 1'b0;
            tx_hdr_valid   <= 1'b0;
            tx_is_write    <= 1'b0;
            tx_addr        <= 64'h0000000000000000;
            tx_len         <= 11'h000;
            tx_data_valid  <= 1'b0;
            tx_data        <= 32'h00000000;
        end else begin
            xstart_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    mm_waitrequest <= 1'b1;
                    if (mm_write) begin
                        mm_waitrequest <= 1'b0;
                        dir_w_reg      <= 1'b1;
                        state_reg      <= S_CMD;
                    end else if (mm_read && free_reg >= mtb_ext(first_len)) begin
                        mm_waitrequest <= 1'b0;
                        dir_w_reg      <= 1'b0;
                        state_reg      <= S_CMD;
                    end
                end
                S_CMD: begin
                    mm_waitrequest <= 1'b1;
                    addr_reg       <= mm_address;
                    rem_reg        <= burst_ext;
                    wbuf_reg       <= mm_writedata;
                    first_reg      <= 1'b1;
                    state_reg      <= S_LOOK;
                end
                S_LOOK: begin
                    chunk_reg  <= mtb_chunk(addr_reg, rem_reg, cfg_max_payload);
                    cnt_reg    <= mtb_chunk(addr_reg, rem_reg, cfg_max_payload);
                    xstart_reg <= 1'b1;
                    state_reg  <= S_WAITX;
                end
                S_WAITX: begin
                    if (xdone) begin
                        tx_addr     <= xaddr;
                        tx_len      <= chunk_reg;
                        tx_is_write <= dir_w_reg;
                        if (!dir_w_reg && free_reg < mtb_ext(chunk_reg)) begin
                            state_reg <= S_CRED;
                        end else begin
                            tx_hdr_valid <= 1'b1;
                            state_reg    <= S_HDR;
                        end
                    end
                end
                S_CRED: begin
                    if (free_reg >= mtb_ext(chunk_reg)) begin
                        tx_hdr_valid <= 1'b1;
                        state_reg    <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (tx_ready) begin
                        tx_hdr_valid <= 1'b0;
                        addr_reg     <= addr_reg + {19'h00000, chunk_reg, 2'b00};
                        rem_reg      <= rem_reg - chunk_reg;
                        if (!dir_w_reg) begin
                            state_reg <= (rem_reg == chunk_reg) ? S_IDLE : S_LOOK;
                        end else begin
                            state_reg <= S_WDATA;
                            if (first_reg) begin
                                tx_data       <= wbuf_reg;
                                tx_data_valid <= 1'b1;
                                first_reg     <= 1'b0;
                            end else begin
                                mm_waitrequest <= 1'b0;
                            end
                        end
                    end
                end
                S_WDATA: begin
                    // last word ends the entry use
                    if (!mm_waitrequest) begin
                        mm_waitrequest <= 1'b1;
                        tx_data        <= mm_writedata;
                        tx_data_valid  <= 1'b1;
                    end else if (tx_data_valid && tx_ready) begin
                        tx_data_valid <= 1'b0;
                        cnt_reg       <= cnt_reg - 11'h001;
                        if (cnt_reg == 11'h001) begin
                            state_reg <= (rem_reg == 11'h000) ? S_IDLE : S_LOOK;
                        end else begin
                            mm_waitrequest <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt signalling
    // ------------------------------------------------------------
    wire msi_on   = cfg_msi_ctrl[`MTB_MSI_EN_BIT];
    wire leg_off  = cfg_command[`MTB_CMD_INTDIS_BIT];

    always @(posedge clk) begin
        if (srst) begin
            irq_prev_reg <= 1'b0;
            legacy_irq   <= 1'b0;
            msi_req      <= 1'b0;
        end else begin
            irq_prev_reg <= app_irq;
            legacy_irq <= app_irq && !msi_on && !leg_off;
            if (!msi_on) begin
                msi_req <= 1'b0;
            end else if (app_irq && !irq_prev_reg) begin
                msi_req <= 1'b1;
            end else if (msi_ack) begin
                msi_req <= 1'b0;
            end
        end
    end

endmodule // mtb_bridge

`default_nettype wire

/* logic/mtb_consts.vh */
`ifndef MTB_CONSTS_VH
`define MTB_CONSTS_VH

// configuration-space interrupt control bit positions
`define MTB_CMD_INTDIS_BIT  10
`define MTB_MSI_EN_BIT      0

// max payload size: code n selects 128 << n bytes, largest code is 4096 bytes
`define MTB_MPS_BASE_BYTES  13'h0080
`define MTB_MPS_MAX_CODE    3'h5

// translation table page count limits
`define MTB_PAGES_MIN       1
`define MTB_PAGES_MAX       512

// request length field width in dwords
`define MTB_LEN_W           11

`endif

/* logic/mtb_xlat.v */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// paged address translation table, two-cycle lookup
// ------------------------------------------------------------
`include "mtb_consts.vh"

module mtb_xlat #(
    parameter PAGES     = 16,
    parameter PAGE_BITS = 20
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   srst,
    // table write port from the controlling master
    input  wire                   wr_en,
    input  wire [8:0]             wr_idx,
    input  wire [63-PAGE_BITS:0]  wr_base,
    // lookup request and result
    input  wire                   look_start,
    input  wire [31:0]            look_addr,
    output reg                    look_done,
    output reg  [63:0]            look_result
);

    localparam NP = (PAGES > `MTB_PAGES_MAX) ? `MTB_PAGES_MAX :
                    (PAGES < `MTB_PAGES_MIN) ? `MTB_PAGES_MIN : PAGES;
    localparam IW = (NP > 1) ? $clog2(NP) : 1;

    reg [63-PAGE_BITS:0] table_mem [0:NP-1];
    reg [IW-1:0]         idx_reg;
    reg [PAGE_BITS-1:0]  off_reg;
    reg                  stage_reg;

    wire [IW-1:0] idx_pick = (NP > 1) ? look_addr[PAGE_BITS +: IW] : {IW{1'b0}};
    wire [IW-1:0] wr_pick  = (NP > 1) ? wr_idx[IW-1:0] : {IW{1'b0}};

    // entries have no reset: software loads them before use
    always @(posedge clk) begin
        if (wr_en) begin
            table_mem[wr_pick] <= wr_base;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            idx_reg     <= {IW{1'b0}};
            off_reg     <= {PAGE_BITS{1'b0}};
            stage_reg   <= 1'b0;
            look_done   <= 1'b0;
            look_result <= 64'h0000000000000000;
        end else begin
            stage_reg <= look_start;
            look_done <= stage_reg;
            if (look_start) begin
                idx_reg <= idx_pick;
                off_reg <= look_addr[PAGE_BITS-1:0];
            end
            if (stage_reg) begin
                look_result <= {table_mem[idx_reg], off_reg};
            end
        end
    end

endmodule // mtb_xlat

`default_nettype wire

/* testbench/mtb_bridge_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the bridge
// ------------------------------------------------------------
module mtb_bridge_chk #(
    parameter CPL_BUF_DW = 1024
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // slave port
    input wire logic        mm_read,
    input wire logic        mm_waitrequest,
    // configuration
    input wire logic [2:0]  cfg_max_payload,
    input wire logic [15:0] cfg_command,
    input wire logic [15:0] cfg_msi_ctrl,
    // request and completion side
    input wire logic        tx_ready,
    input wire logic        tx_hdr_valid,
    input wire logic        tx_is_write,
    input wire logic [63:0] tx_addr,
    input wire logic [10:0] tx_len,
    input wire logic        cpl_valid,
    // interrupts
    input wire logic        app_irq,
    input wire logic        legacy_irq,
    input wire logic        msi_req
);
    logic [12:0] mps_b;
    logic [15:0] out_reg;
    logic [15:0] out_next;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // outstanding read dwords; counted here so a wrapped credit shows up
    always_comb begin
        mps_b = 13'h0080 << ((cfg_max_payload > 3'h5) ? 3'h5 : cfg_max_payload);
        out_next = out_reg;
        if (tx_hdr_valid && tx_ready && !tx_is_write)
            out_next = out_reg + 16'(tx_len);
        if (cpl_valid)
            out_next = out_next - 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            out_reg <= 16'h0000;
        end else begin
            out_reg <= out_next;
        end
    end
    chk_credit_cap: assert property (out_reg <= CPL_BUF_DW)
        else $error("completion space overcommitted");
    chk_stall_free: assert property (
        mm_read && mm_waitrequest && out_reg == 16'h0000 |-> ##[1:60] !mm_waitrequest)
        else $error("read stall not released");
    chk_chunk_fit: assert property (
        tx_hdr_valid |-> tx_len != 11'h000 && 14'(tx_addr[12:0] & (mps_b - 13'h0001))
            + 14'({tx_len, 2'b00}) <= 14'(mps_b))
        else $error("packet crosses payload boundary");
    chk_hdr_hold: assert property (
        tx_hdr_valid && !tx_ready |=> tx_hdr_valid && $stable(tx_addr) && $stable(tx_len))
        else $error("header changed before accept");
    chk_irq_excl: assert property (!(legacy_irq && msi_req))
        else $error("both interrupt methods active");
    chk_legacy_off: assert property (cfg_command[10] |=> !legacy_irq)
        else $error("legacy interrupt while disabled");
    chk_legacy_on: assert property (
        app_irq && !cfg_msi_ctrl[0] && !cfg_command[10] |=> legacy_irq)
        else $error("legacy interrupt missing");
    chk_msi_off: assert property (!cfg_msi_ctrl[0] |=> !msi_req)
        else $error("message interrupt while disabled");
    chk_msi_set: assert property ($rose(app_irq) && cfg_msi_ctrl[0] |=> msi_req)
        else $error("message interrupt missing");
endmodule // mtb_bridge_chk

bind mtb_bridge mtb_bridge_chk #(.CPL_BUF_DW(CPL_BUF_DW)) u_chk (
    .clk, .srst, .mm_read, .mm_waitrequest, .cfg_max_payload, .cfg_command,
    .cfg_msi_ctrl, .tx_ready, .tx_hdr_valid, .tx_is_write, .tx_addr, .tx_len,
    .cpl_valid, .app_irq, .legacy_irq, .msi_req);
`default_nettype wire

/* testbench/mtb_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// link-side sink and completer
// ------------------------------------------------------------
module mtb_link_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // completion stall from the bench
    input  wire logic        hold_cpl,
    // request packets
    input  wire logic        tx_hdr_valid,
    input  wire logic        tx_is_write,
    input  wire logic [63:0] tx_addr,
    input  wire logic [10:0] tx_len,
    output logic             tx_ready,
    // completion data
    output logic             cpl_valid,
    output logic [31:0]      cpl_data
);
    logic [7:0]  lfsr_reg;
    logic [31:0] pend [$];
    initial begin
        tx_ready = 1'b0;
        cpl_valid = 1'b0;
        cpl_data = 32'h0000_0000;
    end
    // ready and completions come in irregular bursts, never all at once
    always @(posedge clk) begin
        if (srst) begin
            lfsr_reg <= 8'h5B;
            tx_ready <= 1'b0;
            cpl_valid <= 1'b0;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            tx_ready <= lfsr_reg[0] | lfsr_reg[3];
            if (tx_hdr_valid && tx_ready && !tx_is_write)
                for (int k = 0; k < tx_len; k++) pend.push_back(tx_addr[31:0] + 32'(4 * k));
            if (!hold_cpl && pend.size() != 0 && lfsr_reg[1]) begin
                cpl_valid <= 1'b1;
                cpl_data <= pend.pop_front();
            end else begin
                // idle data is inverted so nothing relies on a stale word
                cpl_valid <= 1'b0;
                cpl_data <= ~cpl_data;
            end
        end
    end
endmodule // mtb_link_model
`default_nettype wire

/* testbench/mm_to_pcie_tx_bridge_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t exp=%0h got=%0h", $time, (e), (a)); end end

module mm_to_pcie_tx_bridge_bench;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        srst, mm_read, mm_write, tbl_wr, app_irq, msi_ack, hold_cpl;
    logic        mm_waitrequest, mm_readdatavalid, tx_ready, tx_hdr_valid, tx_is_write;
    logic        tx_data_valid, cpl_valid, legacy_irq, msi_req;
    logic [31:0] mm_address, mm_writedata, mm_readdata, tx_data, cpl_data, wbase, ew;
    logic [7:0]  mm_burstcount;
    logic [8:0]  tbl_idx;
    logic [43:0] tbl_base;
    logic [43:0] tb_tbl [4];
    logic [2:0]  cfg_max_payload;
    logic [15:0] cfg_command, cfg_msi_ctrl;
    logic [63:0] tx_addr;
    logic [10:0] tx_len;
    logic [75:0] eh;
    logic [75:0] hq [$];
    logic [31:0] wq [$];
    logic [31:0] rq [$];
    int          seed, n_errors, comparisons;

    always #10 clk = ~clk;

    mtb_bridge #(.PAGES(4), .CPL_BUF_DW(8)) dut (.clk, .srst, .mm_address, .mm_read,
        .mm_write, .mm_writedata, .mm_burstcount, .mm_waitrequest, .mm_readdata,
        .mm_readdatavalid, .tbl_wr, .tbl_idx, .tbl_base, .cfg_max_payload, .cfg_command,
        .cfg_msi_ctrl, .tx_ready, .tx_hdr_valid, .tx_is_write, .tx_addr, .tx_len,
        .tx_data_valid, .tx_data, .cpl_valid, .cpl_data, .app_irq, .msi_ack, .legacy_irq,
        .msi_req);
    mtb_link_model link (.clk, .srst, .hold_cpl, .tx_hdr_valid, .tx_is_write, .tx_addr,
        .tx_len, .tx_ready, .cpl_valid, .cpl_data);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task tbl_set(input int i);
        @(negedge clk);
        tbl_wr = 1'b1;
        tbl_idx = 9'(i);
        tbl_base = 44'({$random(seed), $random(seed)});
        tb_tbl[i] = tbl_base;
        @(negedge clk);
        tbl_wr = 1'b0;
    endtask

    // expected packets: chunk ends at the next payload boundary
    task plan(input logic wr, input logic [31:0] a, input int n);
        int c, j;
        logic [63:0] t;
        logic [12:0] b;
        j = 0;
        b = 13'h0080 << ((cfg_max_payload > 3'h5) ? 3'h5 : cfg_max_payload);
        while (n > 0) begin
            c = (b - (a % b)) / 4;
            if (c > n) c = n;
            t = {tb_tbl[a[21:20]], a[19:0]};
            hq.push_back({wr, t, 11'(c)});
            for (int k = 0; k < c; k++) begin
                if (wr) wq.push_back(wbase + 32'(j + k));
                else rq.push_back(t[31:0] + 32'(4 * k));
            end
            a = a + 32'(4 * c);
            n = n - c;
            j = j + c;
        end
    endtask

    task xfer(input logic wr, input logic [31:0] a, input int n);
        int i, t;
        wbase = $random(seed);
        plan(wr, a, n);
        i = 0;
        t = 0;
        @(negedge clk);
        mm_address = a;
        mm_burstcount = 8'(n);
        mm_writedata = wbase;
        mm_read = !wr;
        mm_write = wr;
        while (i < (wr ? n : 1) && t < 3000) begin
            @(posedge clk);
            t++;
            if (mm_waitrequest === 1'b0) i++;
            @(negedge clk);
            mm_writedata = wbase + 32'(i);
            if (i == (wr ? n : 1)) {mm_read, mm_write} = 2'b00;
        end
        `CHK(1'b0, t >= 3000)
    endtask

    task idle;
        int t;
        t = 0;
        while (hq.size() + wq.size() + rq.size() != 0 && t < 3000) begin
            @(negedge clk);
            t++;
        end
        `CHK(1'b0, t == 3000)
        repeat (4) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if ((!srst & tx_hdr_valid & tx_ready) === 1'b1) begin
            eh = hq.pop_front();
            `CHK(eh, {tx_is_write, tx_addr, tx_len})
        end
        if ((!srst & tx_data_valid & tx_ready) === 1'b1) begin
            ew = wq.pop_front();
            `CHK(ew, tx_data)
        end
        if (mm_readdatavalid === 1'b1) begin
            ew = rq.pop_front();
            `CHK(ew, mm_readdata)
        end
    end

    // run is a few thousand cycles; the limit is far beyond that
    initial begin
        #1000000;
        n_errors++;
        end_sim;
    end

    initial begin
        seed = 73;
        n_errors = 0;
        comparisons = 0;
        {srst, hold_cpl, mm_read, mm_write, tbl_wr, app_irq, msi_ack} = 7'h60;
        {mm_address, mm_writedata, wbase, tbl_base} = 140'h0;
        {mm_burstcount, tbl_idx, cfg_max_payload} = 20'h00100;
        {cfg_command, cfg_msi_ctrl} = 32'h0;
        repeat (20) @(negedge clk);
        {srst, hold_cpl} = 2'b00;
        for (int i = 0; i < 4; i++) tbl_set(i);
        xfer(1'b1, 32'h0050_0000, 2);
        idle;
        for (int m = 0; m < 8; m++) begin
            cfg_max_payload = 3'(m);
            xfer(1'b1, 32'h0010_0000 + (32'h80 << (m > 5 ? 5 : m)) - 32'h10, 40);
            xfer(1'b0, 32'h0020_0000 + (32'h80 << (m > 5 ? 5 : m)) - 32'h8, 8);
            idle;
        end
        for (int k = 0; k < 12; k++)
            xfer(1'b0, {10'h000, 2'(k), 20'($random(seed)) & 20'hFFFFC},
                1 + $unsigned($random(seed)) % 8);
        idle;
        for (int i = 0; i < 4; i++) tbl_set(i);
        cfg_max_payload = 3'h0;
        hold_cpl = 1'b1;
        xfer(1'b0, 32'h0000_0100, 8);
        while (hq.size() != 0) @(negedge clk);
        fork
            xfer(1'b0, 32'h0000_0200, 1);
        join_none
        repeat (30) begin
            @(negedge clk);
            `CHK(1'b1, mm_waitrequest)
        end
        hold_cpl = 1'b0;
        idle;
        for (int k = 0; k < 4; k++) begin
            cfg_command = 16'(k & 1) << 10;
            cfg_msi_ctrl = 16'(k >> 1);
            repeat (2) @(negedge clk);
            app_irq = 1'b1;
            repeat (3) @(negedge clk);
            `CHK(!k[0] && !k[1], legacy_irq)
            `CHK(k[1], msi_req)
            msi_ack = 1'b1;
            @(negedge clk);
            {msi_ack, app_irq} = 2'b00;
            @(negedge clk);
            `CHK(1'b0, msi_req)
        end
        end_sim;
    end
endmodule // mm_to_pcie_tx_bridge_bench
`default_nettype wire
